// file: hdl/dcs_pkg.sv
package dcs_pkg;
    // ========================================
    // Register byte offsets.
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_KEYFREQ = 8'h04;
    localparam logic [7:0] REG_STEP1 = 8'h08;
    localparam logic [7:0] REG_STEP7 = 8'h20;
    localparam logic [7:0] REG_STATUS = 8'h24;
    localparam logic [7:0] REG_FREQ = 8'h28;
    localparam logic [7:0] REG_PANEL = 8'h2C;
    // ========================================
    // Control register field positions.
    localparam int CTRL_RUN_SRC = 0;
    localparam int CTRL_FREQ_SRC = 1;
    localparam int CTRL_METER_PULSE = 2;
    // ========================================
    // Reset values.
    localparam logic [15:0] KEYFREQ_RST = 16'h0000;
    localparam logic [15:0] STEP_RST = 16'h0000;
    localparam logic [4:0] CODE_RST = 5'h00;
    // ========================================
    // Parameter codes reachable from the keypad.
    localparam logic [4:0] CODE_FREQ_SRC = 5'h01;
    localparam logic [4:0] CODE_RUN_SRC = 5'h02;
    localparam logic [4:0] CODE_STEP1 = 5'h15;
    localparam logic [4:0] CODE_STEP7 = 5'h1B;
    localparam logic [4:0] CODE_METER = 5'h1C;
    // ========================================
    // Bit positions of the synchronised pin vector.
    localparam int PIN_W = 15;
    localparam int IN_FWD = 0;
    localparam int IN_REV = 1;
    localparam int IN_STEP0 = 2;
    localparam int IN_RAMP = 5;
    localparam int IN_EXT_STOP = 6;
    localparam int IN_RST_COAST = 7;
    localparam int IN_RUN_KEY = 8;
    localparam int IN_STOP_KEY = 9;
    localparam int IN_PRG_KEY = 10;
    localparam int IN_FUNC_KEY = 11;
    localparam int IN_UP_KEY = 12;
    localparam int IN_DOWN_KEY = 13;
    localparam int IN_TRIP = 14;
    // ========================================
    // Bus responses.
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// file: hdl/dcs_top.sv
`timescale 1ns/1ps
module dcs_top
    import dcs_pkg::*;
(
    input wire logic MCLK,
    input wire logic NRST,
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic FORWARD_CMD_IN,
    input wire logic REVERSE_CMD_IN,
    input wire logic STEP_SEL_0,
    input wire logic STEP_SEL_1,
    input wire logic STEP_SEL_2,
    input wire logic RAMP_SET_SEL,
    input wire logic EXTERNAL_STOP_IN,
    input wire logic RESET_COAST_IN,
    input wire logic RUN_KEY,
    input wire logic STOP_KEY,
    input wire logic PROGRAM_KEY,
    input wire logic FUNC_DATA_KEY,
    input wire logic UP_KEY,
    input wire logic DOWN_KEY,
    input wire logic PROT_TRIP_IN,
    input wire logic [11:0] CURRENT_REF_IN,
    input wire logic [11:0] VOLTAGE_REF_IN,
    input wire logic MOTOR_STOPPED,
    input wire logic FREQ_PULSE_IN,
    output logic RUN_CMD,
    output logic DIR_REV,
    output logic COAST_CMD,
    output logic RAMP_SET2,
    output logic [15:0] FREQ_REF,
    output logic ALARM_RELAY_OUT,
    output logic RUNNING_OUT,
    output logic [15:0] ANALOG_METER_OUT,
    output logic PULSE_METER_OUT,
    output logic PROG_MODE,
    output logic DISP_IS_CODE,
    output logic [15:0] DISP_VALUE
);

    // ========================================
    // State.
    typedef struct packed {
        logic [PIN_W-1:0] sync1;
        logic [PIN_W-1:0] sync2;
        logic [PIN_W-1:0] key_prev;
        logic run_src;
        logic freq_src;
        logic meter_pulse;
        logic [15:0] keypad_freq;
        logic [6:0][15:0] step_freq;
        logic keypad_run;
        logic fault;
        logic coast;
        logic run_cmd;
        logic dir_rev;
        logic ramp2;
        logic [15:0] freq_ref;
        logic alarm;
        logic running;
        logic [15:0] ameter;
        logic pmeter;
        logic prog;
        logic show_code;
        logic [4:0] code;
        logic [15:0] edit;
        logic aw_held;
        logic [7:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } dcs_state_t;

    dcs_state_t s;
    dcs_state_t n;

    logic [PIN_W-1:0] pins;
    logic [PIN_W-1:0] press;
    logic forward_cmd_in;
    logic reverse_cmd_in;
    logic term_closed;
    logic ext_ok;
    logic [2:0] step_idx;
    logic [15:0] analog_sum;
    logic wr_go;
    logic ar_take;
    logic [15:0] code_value;

    // Pins gathered into one vector for the synchroniser.
    assign pins = {PROT_TRIP_IN, DOWN_KEY, UP_KEY, FUNC_DATA_KEY, PROGRAM_KEY, STOP_KEY, RUN_KEY,
                   RESET_COAST_IN, EXTERNAL_STOP_IN, RAMP_SET_SEL, STEP_SEL_2, STEP_SEL_1, STEP_SEL_0,
                   REVERSE_CMD_IN, FORWARD_CMD_IN};

    // Decoded pin levels from the second stage; key presses compare it with key_prev, its value one cycle earlier.
    assign press = s.sync2 & ~s.key_prev;
    assign forward_cmd_in = s.sync2[IN_FWD];
    assign reverse_cmd_in = s.sync2[IN_REV];
    assign term_closed = forward_cmd_in | reverse_cmd_in;
    assign ext_ok = s.sync2[IN_EXT_STOP];
    assign step_idx = s.sync2[IN_STEP0+2:IN_STEP0];
    assign analog_sum = {3'b000, {1'b0, CURRENT_REF_IN} + {1'b0, VOLTAGE_REF_IN}};

    // Bus handshakes; a write runs once address and data are both held.
    assign S_AXI_AWREADY = !s.aw_held && !s.bvalid;
    assign S_AXI_WREADY = !s.w_held && !s.bvalid;
    assign S_AXI_ARREADY = !s.rvalid;
    assign wr_go = s.aw_held && s.w_held && !s.bvalid;
    assign ar_take = S_AXI_ARVALID && !s.rvalid;

    // Current stored value of the parameter code shown on the panel.
    always_comb begin
        case (s.code)
            CODE_FREQ_SRC: code_value = {15'h0000, s.freq_src};
            CODE_RUN_SRC: code_value = {15'h0000, s.run_src};
            CODE_METER: code_value = {15'h0000, s.meter_pulse};
            default: begin
                if (s.code >= CODE_STEP1 && s.code <= CODE_STEP7) begin
                    code_value = s.step_freq[3'(s.code - CODE_STEP1)];
                end else begin
                    code_value = 16'h0000;
                end
            end
        endcase
    end

    // Merges a bus write into a 16-bit register under byte strobes.
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] st);
        logic [15:0] r;
        r = old;
        if (st[0]) r[7:0] = d[7:0];
        if (st[1]) r[15:8] = d[15:8];
        return r;
    endfunction

    // ========================================
    // Next-state logic.
    always_comb begin
        n = s;
        n.sync1 = pins;
        n.sync2 = s.sync1;
        n.key_prev = s.sync2;

        // Bus write channel capture and response release.
        if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            n.aw_held = 1'b1;
            n.aw_addr = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && S_AXI_WREADY) begin
            n.w_held = 1'b1;
            n.w_data = S_AXI_WDATA;
            n.w_strb = S_AXI_WSTRB;
        end
        if (s.bvalid && S_AXI_BREADY) begin
            n.bvalid = 1'b0;
        end

        // Keypad program mode and parameter editing.
        if (press[IN_PRG_KEY]) begin
            n.prog = !s.prog;
            n.show_code = 1'b1;
        end else if (s.prog) begin
            if (press[IN_FUNC_KEY]) begin
                if (s.show_code) begin
                    n.show_code = 1'b0;
                    n.edit = code_value;
                end else begin
                    n.show_code = 1'b1;
                    n.code = s.code + 5'h01;
                    case (s.code)
                        CODE_FREQ_SRC: n.freq_src = s.edit[0];
                        CODE_RUN_SRC: begin
                            if (!term_closed) begin
                                n.run_src = s.edit[0];
                            end
                        end
                        CODE_METER: n.meter_pulse = s.edit[0];
                        default: begin
                            if (s.code >= CODE_STEP1 && s.code <= CODE_STEP7) begin
                                n.step_freq[3'(s.code - CODE_STEP1)] = s.edit;
                            end
                        end
                    endcase
                end
            end else if (press[IN_UP_KEY] && !press[IN_DOWN_KEY]) begin
                if (s.show_code) begin
                    n.code = s.code + 5'h01;
                end else begin
                    n.edit = s.edit + 16'h0001;
                end
            end else if (press[IN_DOWN_KEY] && !press[IN_UP_KEY]) begin
                if (s.show_code) begin
                    n.code = s.code - 5'h01;
                end else begin
                    n.edit = s.edit - 16'h0001;
                end
            end
        end else begin
            // Outside program mode the arrows trim the keypad frequency, saturating.
            if (press[IN_UP_KEY] && !press[IN_DOWN_KEY] && s.keypad_freq != 16'hFFFF) begin
                n.keypad_freq = s.keypad_freq + 16'h0001;
            end else if (press[IN_DOWN_KEY] && !press[IN_UP_KEY] && s.keypad_freq != 16'h0000) begin
                n.keypad_freq = s.keypad_freq - 16'h0001;
            end
        end

        // Register writes from the bus, applied after keypad edits.
        if (wr_go) begin
            n.aw_held = 1'b0;
            n.w_held = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = RESP_OKAY;
            if (s.aw_addr == REG_CTRL) begin
                if (s.w_strb[0]) begin
                    if (!term_closed) begin
                        n.run_src = s.w_data[CTRL_RUN_SRC];
                    end
                    n.freq_src = s.w_data[CTRL_FREQ_SRC];
                    n.meter_pulse = s.w_data[CTRL_METER_PULSE];
                end
            end else if (s.aw_addr == REG_KEYFREQ) begin
                n.keypad_freq = merge16(s.keypad_freq, s.w_data, s.w_strb);
            end else if (s.aw_addr >= REG_STEP1 && s.aw_addr <= REG_STEP7 && s.aw_addr[1:0] == 2'b00) begin
                n.step_freq[3'((s.aw_addr - REG_STEP1) >> 2)] =
                    merge16(s.step_freq[3'((s.aw_addr - REG_STEP1) >> 2)], s.w_data, s.w_strb);
            end else if (s.aw_addr != REG_STATUS && s.aw_addr != REG_FREQ && s.aw_addr != REG_PANEL) begin
                n.bresp = RESP_SLVERR;
            end
        end

        // Bus reads.
        if (s.rvalid && S_AXI_RREADY) begin
            n.rvalid = 1'b0;
        end
        if (ar_take) begin
            n.rvalid = 1'b1;
            n.rresp = RESP_OKAY;
            n.rdata = 32'h0000_0000;
            if (S_AXI_ARADDR == REG_CTRL) begin
                n.rdata[CTRL_RUN_SRC] = s.run_src;
                n.rdata[CTRL_FREQ_SRC] = s.freq_src;
                n.rdata[CTRL_METER_PULSE] = s.meter_pulse;
            end else if (S_AXI_ARADDR == REG_KEYFREQ) begin
                n.rdata[15:0] = s.keypad_freq;
            end else if (S_AXI_ARADDR >= REG_STEP1 && S_AXI_ARADDR <= REG_STEP7 && S_AXI_ARADDR[1:0] == 2'b00) begin
                n.rdata[15:0] = s.step_freq[3'((S_AXI_ARADDR - REG_STEP1) >> 2)];
            end else if (S_AXI_ARADDR == REG_STATUS) begin
                n.rdata[10:0] = {s.show_code, s.prog, step_idx, s.ramp2, s.coast, s.fault,
                                 s.dir_rev, s.run_cmd, s.running};
            end else if (S_AXI_ARADDR == REG_FREQ) begin
                n.rdata[15:0] = s.freq_ref;
            end else if (S_AXI_ARADDR == REG_PANEL) begin
                n.rdata = {s.edit, 11'h000, s.code};
            end else begin
                n.rresp = RESP_SLVERR;
            end
        end

        // Fault latch: reset/coast clears it, a trip in the same cycle wins.
        if (press[IN_RST_COAST] && s.fault) begin
            n.fault = 1'b0;
        end else if (press[IN_RST_COAST] && s.running) begin
            n.coast = 1'b1;
        end
        if (s.sync2[IN_TRIP]) begin
            n.fault = 1'b1;
        end
        if (s.coast && MOTOR_STOPPED) begin
            n.coast = 1'b0;
        end

        // Keypad run latch.
        if (press[IN_RUN_KEY] && !s.run_src) begin
            n.keypad_run = 1'b1;
        end
        if (press[IN_STOP_KEY] || !ext_ok || n.fault || n.coast) begin
            n.keypad_run = 1'b0;
        end

        // Run command and direction.
        if (s.run_src) begin
            n.run_cmd = (forward_cmd_in ^ reverse_cmd_in) && ext_ok && !n.fault && !n.coast;
            if (forward_cmd_in ^ reverse_cmd_in) begin
                n.dir_rev = reverse_cmd_in;
            end
        end else begin
            n.run_cmd = n.keypad_run && ext_ok && !n.fault && !n.coast;
            n.dir_rev = 1'b0;
        end

        // Frequency reference selection.
        if (step_idx != 3'b000) begin
            n.freq_ref = s.step_freq[step_idx - 3'b001];
        end else if (s.freq_src) begin
            n.freq_ref = analog_sum;
        end else begin
            n.freq_ref = s.keypad_freq;
        end

        // Ramp set, status outputs and meter exclusivity.
        n.ramp2 = s.sync2[IN_RAMP];
        n.alarm = s.fault && MOTOR_STOPPED;
        n.running = !MOTOR_STOPPED;
        n.ameter = s.meter_pulse ? 16'h0000 : s.freq_ref;
        n.pmeter = s.meter_pulse && FREQ_PULSE_IN;
    end

    // ========================================
    // State register.
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            s <= '0;
            s.keypad_freq <= KEYFREQ_RST;
            s.step_freq <= {7{STEP_RST}};
            s.code <= CODE_RST;
            s.show_code <= 1'b1;
            s.sync1[IN_EXT_STOP] <= 1'b1;
            s.sync2[IN_EXT_STOP] <= 1'b1;
            s.key_prev <= {PIN_W{1'b1}};
        end else begin
            s <= n;
        end
    end

    // Outputs straight from the state register.
    assign S_AXI_BVALID = s.bvalid;
    assign S_AXI_BRESP = s.bresp;
    assign S_AXI_RVALID = s.rvalid;
    assign S_AXI_RDATA = s.rdata;
    assign S_AXI_RRESP = s.rresp;
    assign RUN_CMD = s.run_cmd;
    assign DIR_REV = s.dir_rev;
    assign COAST_CMD = s.coast;
    assign RAMP_SET2 = s.ramp2;
    assign FREQ_REF = s.freq_ref;
    assign ALARM_RELAY_OUT = s.alarm;
    assign RUNNING_OUT = s.running;
    assign ANALOG_METER_OUT = s.ameter;
    assign PULSE_METER_OUT = s.pmeter;
    assign PROG_MODE = s.prog;
    assign DISP_IS_CODE = s.show_code;
    assign DISP_VALUE = s.show_code ? {11'h000, s.code} : s.edit;

    // ========================================
    // Assertions.
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!NRST);

    src_keypad_a: assert property (!s.run_src && press[IN_RUN_KEY] && !press[IN_STOP_KEY] && ext_ok
        && !n.fault && !n.coast |=> RUN_CMD && !DIR_REV) else $error("Keypad run key did not start the drive.");
    ref_select_a: assert property (step_idx == 3'b000 && s.freq_src |=> FREQ_REF == $past(analog_sum))
        else $error("Analog reference not selected.");
    src_lock_a: assert property (wr_go && s.aw_addr == REG_CTRL && term_closed |=> $stable(s.run_src))
        else $error("Run source changed while terminals closed.");
    fwd_run_a: assert property (s.run_src && forward_cmd_in && !reverse_cmd_in && ext_ok && !n.fault && !n.coast
        |=> RUN_CMD && !DIR_REV) else $error("Forward terminal did not run forward.");
    both_stop_a: assert property (s.run_src && (forward_cmd_in == reverse_cmd_in) |=> !RUN_CMD)
        else $error("Equal terminals did not stop the drive.");
    step_ref_a: assert property (step_idx != 3'b000 |=> FREQ_REF == $past(s.step_freq[step_idx - 3'b001]))
        else $error("Step frequency not followed.");
    ramp_sel_a: assert property (s.sync2[IN_RAMP] && step_idx != 3'b000 |=> RAMP_SET2)
        else $error("Ramp set 2 not used during multistep.");
    alarm_relay_a: assert property (s.fault && MOTOR_STOPPED && !press[IN_RST_COAST] |=> ALARM_RELAY_OUT)
        else $error("Alarm relay did not switch.");
    running_out_a: assert property (!MOTOR_STOPPED |=> RUNNING_OUT)
        else $error("Running output not on.");
    meter_excl_a: assert property (s.meter_pulse |=> ANALOG_METER_OUT == 16'h0000
        && PULSE_METER_OUT == $past(FREQ_PULSE_IN)) else $error("Meter outputs not exclusive.");
    ext_stop_a: assert property (!ext_ok |=> !RUN_CMD) else $error("External stop ignored.");
    fault_clear_a: assert property (s.fault && press[IN_RST_COAST] && !s.sync2[IN_TRIP] |=> !s.fault)
        else $error("Fault not cleared.");
    func_store_a: assert property (s.prog && !s.show_code && press[IN_FUNC_KEY] && !press[IN_PRG_KEY]
        |=> DISP_IS_CODE && s.code == $past(s.code) + 5'h01) else $error("Store did not advance code.");
    code_step_a: assert property (s.prog && s.show_code && press[IN_UP_KEY] && !press[IN_DOWN_KEY]
        && !press[IN_PRG_KEY] && !press[IN_FUNC_KEY] |=> s.code == $past(s.code) + 5'h01)
        else $error("Up key did not step the code.");

    fwd_run_c: cover property (s.run_src && forward_cmd_in && !reverse_cmd_in ##3 RUN_CMD);
    step_use_c: cover property (step_idx == 3'b101 ##2 RUN_CMD);
    fault_cycle_c: cover property (s.fault ##[1:20] !s.fault);
    store_c: cover property (s.prog && !s.show_code && press[IN_FUNC_KEY]);
endmodule

// file: verification/dcs_motor_model.sv
`timescale 1ns/1ps
// ========================================
// Motor and power stage model
module dcs_motor_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic run_cmd,
    input wire logic coast_cmd,
    output logic stopped,
    output logic pulse
);
    logic [2:0] speed;
    // Speed ramps while running, and coasting drops it at once.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            speed <= 3'h0;
            pulse <= 1'h0;
        end else begin
            if (coast_cmd) speed <= 3'h0;
            else if (run_cmd && speed != 3'h4) speed <= speed + 3'h1;
            else if (!run_cmd && speed != 3'h0) speed <= speed - 3'h1;
            pulse <= (speed != 3'h0) ? !pulse : 1'h0;
        end
    end
    // The shaft is at rest only at zero speed.
    assign stopped = (speed == 3'h0);
endmodule

// file: verification/drive_command_select_bench.sv
`timescale 1ns/1ps
module drive_command_select_bench
    import dcs_pkg::*;
;
    // ========================================
    // Signals
    localparam logic [31:0] ONE = 32'h0000_0001;
    localparam logic [31:0] ZERO = 32'h0000_0000;
    logic MCLK = 1'h0, NRST = 1'h0;
    logic [7:0] S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00;
    logic [31:0] S_AXI_WDATA = ZERO, S_AXI_RDATA;
    logic [3:0] S_AXI_WSTRB = 4'hF;
    logic S_AXI_AWVALID = 1'h0, S_AXI_WVALID = 1'h0, S_AXI_BREADY = 1'h0;
    logic S_AXI_ARVALID = 1'h0, S_AXI_RREADY = 1'h0;
    logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
    logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
    logic FORWARD_CMD_IN = 1'h0, REVERSE_CMD_IN = 1'h0, RAMP_SET_SEL = 1'h0;
    logic EXTERNAL_STOP_IN = 1'h1, RESET_COAST_IN = 1'h0, PROT_TRIP_IN = 1'h0;
    logic [11:0] CURRENT_REF_IN = 12'h000, VOLTAGE_REF_IN = 12'h000;
    logic [2:0] sel = 3'h0;
    logic [5:0] keys = 6'h00;
    wire STEP_SEL_0 = sel[0], STEP_SEL_1 = sel[1], STEP_SEL_2 = sel[2];
    wire RUN_KEY = keys[0], STOP_KEY = keys[1], PROGRAM_KEY = keys[2];
    wire FUNC_DATA_KEY = keys[3], UP_KEY = keys[4], DOWN_KEY = keys[5];
    logic MOTOR_STOPPED, FREQ_PULSE_IN, RUN_CMD, DIR_REV, COAST_CMD, RAMP_SET2;
    logic ALARM_RELAY_OUT, RUNNING_OUT, PULSE_METER_OUT, PROG_MODE, DISP_IS_CODE;
    logic [15:0] FREQ_REF, ANALOG_METER_OUT, DISP_VALUE;
    int err_total = 0, total_checks = 0, cyc = 0;
    dcs_top dcs_top_inst (.*);
    dcs_motor_model dcs_motor_model_inst (.clk(MCLK), .rst_n(NRST), .run_cmd(RUN_CMD),
        .coast_cmd(COAST_CMD), .stopped(MOTOR_STOPPED), .pulse(FREQ_PULSE_IN));
    // Free-running 25 MHz clock.
    always #20 MCLK = ~MCLK;
    // ========================================
    // Tasks
    task automatic test_done();
        if (err_total == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic w(input int n);
        repeat (n) @(posedge MCLK);
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // Bus write: address and data offered together, each released when taken.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        @(posedge MCLK);
        S_AXI_AWADDR <= a;
        S_AXI_WDATA <= d;
        S_AXI_AWVALID <= 1'h1;
        S_AXI_WVALID <= 1'h1;
        S_AXI_BREADY <= 1'h1;
        tb = 1'h0;
        while (!tb) begin
            @(negedge MCLK);
            ta = S_AXI_AWVALID && S_AXI_AWREADY;
            tw = S_AXI_WVALID && S_AXI_WREADY;
            tb = S_AXI_BVALID;
            @(posedge MCLK);
            if (ta) S_AXI_AWVALID <= 1'h0;
            if (tw) S_AXI_WVALID <= 1'h0;
        end
        chk({30'h0, S_AXI_BRESP}, {30'h0, RESP_OKAY});
        S_AXI_BREADY <= 1'h0;
    endtask
    // Bus read with comparison of data and response.
    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        logic ta, tr;
        @(posedge MCLK);
        S_AXI_ARADDR <= a;
        S_AXI_ARVALID <= 1'h1;
        S_AXI_RREADY <= 1'h1;
        tr = 1'h0;
        while (!tr) begin
            @(negedge MCLK);
            ta = S_AXI_ARVALID && S_AXI_ARREADY;
            tr = S_AXI_RVALID;
            @(posedge MCLK);
            if (ta) S_AXI_ARVALID <= 1'h0;
        end
        chk(S_AXI_RDATA, e);
        chk({30'h0, S_AXI_RRESP}, {30'h0, er});
        S_AXI_RREADY <= 1'h0;
    endtask
    // One key press with a release gap after it.
    task automatic press(input int b);
        keys[b] <= 1'h1;
        w(4);
        keys[b] <= 1'h0;
        w(6);
    endtask
    // Cuts a hung run short.
    always @(posedge MCLK) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            test_done();
        end
    end
    // ========================================
    // Main sequence
    initial begin
        w(20);
        NRST <= 1'h1;
        rdc(REG_CTRL, ZERO, RESP_OKAY);
        wr(REG_KEYFREQ, 32'h0000_1234);
        w(3);
        chk(FREQ_REF, 32'h0000_1234);
        for (int i = 1; i < 8; i++) wr(REG_STEP1 + 8'(4 * (i - 1)), 32'h0000_0100 + i);
        for (int i = 1; i < 8; i++) begin
            sel <= 3'(i);
            w(5);
            chk(FREQ_REF, 32'h0000_0100 + i);
        end
        RAMP_SET_SEL <= 1'h1;
        w(5);
        chk(RAMP_SET2, ONE);
        chk(FREQ_REF, 32'h0000_0107);
        sel <= 3'h0;
        RAMP_SET_SEL <= 1'h0;
        w(5);
        chk(FREQ_REF, 32'h0000_1234);
        chk(RAMP_SET2, ZERO);
        wr(REG_CTRL, 32'h0000_0002);
        CURRENT_REF_IN <= 12'hFFF;
        VOLTAGE_REF_IN <= 12'h001;
        w(5);
        chk(FREQ_REF, 32'h0000_1000);
        chk(ANALOG_METER_OUT, 32'h0000_1000);
        press(0);
        chk(RUN_CMD, ONE);
        w(8);
        chk(RUNNING_OUT, ONE);
        chk(PULSE_METER_OUT, ZERO);
        press(1);
        chk(RUN_CMD, ZERO);
        w(10);
        chk(RUNNING_OUT, ZERO);
        wr(REG_CTRL, ONE);
        FORWARD_CMD_IN <= 1'h1;
        w(5);
        chk(RUN_CMD, ONE);
        chk(DIR_REV, ZERO);
        EXTERNAL_STOP_IN <= 1'h0;
        w(5);
        chk(RUN_CMD, ZERO);
        EXTERNAL_STOP_IN <= 1'h1;
        wr(REG_CTRL, ZERO);
        rdc(REG_CTRL, ONE, RESP_OKAY);
        REVERSE_CMD_IN <= 1'h1;
        w(5);
        chk(RUN_CMD, ZERO);
        FORWARD_CMD_IN <= 1'h0;
        w(8);
        chk(RUN_CMD, ONE);
        chk(DIR_REV, ONE);
        RESET_COAST_IN <= 1'h1;
        w(4);
        chk(COAST_CMD, ONE);
        RESET_COAST_IN <= 1'h0;
        REVERSE_CMD_IN <= 1'h0;
        PROT_TRIP_IN <= 1'h1;
        w(10);
        PROT_TRIP_IN <= 1'h0;
        w(5);
        chk(ALARM_RELAY_OUT, ONE);
        RESET_COAST_IN <= 1'h1;
        w(5);
        chk(ALARM_RELAY_OUT, ZERO);
        wr(REG_CTRL, 32'h0000_0004);
        w(3);
        chk(ANALOG_METER_OUT, ZERO);
        press(2);
        chk(PROG_MODE, ONE);
        chk(DISP_IS_CODE, ONE);
        press(4);
        chk(DISP_VALUE, ONE);
        press(3);
        chk(DISP_IS_CODE, ZERO);
        press(4);
        chk(DISP_VALUE, ONE);
        press(3);
        chk(DISP_VALUE, 32'h0000_0002);
        rdc(REG_CTRL, 32'h0000_0006, RESP_OKAY);
        rdc(8'hFC, ZERO, RESP_SLVERR);
        test_done();
    end
endmodule
